/* File: code_slewer.sv */
/*
  Code slew engine: walks the active converter code toward a target by
  a fixed step once per slew interval, or jumps when told to.
  Assumes clock, reset and clock enable shared with the register bank.
*/
module code_slewer
  import dac_regs_pkg::*;
#(
  parameter int         STEP_CYC = SLEW_STEP_CYC,
  parameter logic [9:0] STEP     = SLEW_STEP_LSB
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clockEnable,
  input  wire logic       jump,
  input  wire logic [9:0] jumpCode,
  input  wire logic       slewStart,
  input  wire logic [9:0] slewTarget,
  output logic      [9:0] code_r,
  output logic            slewing_r
);
  logic [15:0] tick_r;
  logic [9:0]  target_r;

  // -----------------------------------------------------------------
  // step toward target; a direct jump overrides any slew in flight
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      code_r    <= CODE_RESET;
      target_r  <= CODE_RESET;
      slewing_r <= 1'b0;
      tick_r    <= 16'h0000;
    end else if (clockEnable) begin
      if (jump) begin
        code_r    <= jumpCode;
        slewing_r <= 1'b0;
      end else if (slewStart) begin
        target_r  <= slewTarget;
        slewing_r <= 1'b1;
        tick_r    <= 16'h0000;
      end else if (slewing_r) begin
        if (code_r == target_r) begin
          slewing_r <= 1'b0;
        end else if (tick_r == 16'(STEP_CYC - 1)) begin
          tick_r <= 16'h0000;
          // clamp so a large step never overshoots the target
          if (code_r < target_r) begin
            code_r <= (target_r - code_r > STEP) ? code_r + STEP : target_r;
          end else begin
            code_r <= (code_r - target_r > STEP) ? code_r - STEP : target_r;
          end
        end else begin
          tick_r <= tick_r + 16'h0001;
        end
      end
    end
  end
endmodule : code_slewer

/* File: dac_code_margin_regs.sv */
/*
  Register bank of a single-channel voltage-output converter: output
  code, upper and lower margin codes, operation command and bus status.
  Assumes a same-clock register port from the serial bus front end,
  which also pulses protocolError on any framing or timing fault.
*/
// Overview of operation
// - code register write sets output immediately
// - codes left aligned bits 11..2, rest ignored
// - eight-bit code uses upper eight field bits
// - upper margin holds margin-high target, resets zero
// - lower margin holds margin-low target code
// - command 00h off, 80h on, readable
// - command A4h moves output to upper margin
// - command 94h moves output to lower margin
// - bus protocol errors set fault bit 9
// - fault reads back in bit 9, cleared by writing one
// - code registers write-only, reset zero, read zero
// - margin trigger bits self-clear on arrival
module dac_code_margin_regs
  import dac_regs_pkg::*;
#(
  parameter int CODE_BITS = 10 // 10 or 8
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clockEnable,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        protocolError,
  input  wire logic [1:0]  powerdownMode,
  output logic      [15:0] regRdata_r,
  output logic      [9:0]  activeCode_r,
  output logic      [1:0]  outputPowerdownSelect_r,
  output logic             commFaultFlag_r,
  output logic             marginHighBusy_r,
  output logic             marginLowBusy_r
);
  logic [9:0] outputCode_r;
  logic [9:0] upperMargin_r;
  logic [9:0] lowerMargin_r;
  logic [7:0] opCommand_r;
  logic [9:0] slewCode;
  logic       slewing;
  logic       wrCode;
  logic       wrCmd;
  logic       startHigh;
  logic       startLow;

  // -----------------------------------------------------------------
  // field extraction
  // -----------------------------------------------------------------
  // eight-bit parts drop the two lowest field bits as don't care
  function automatic logic [9:0] codeField(input logic [15:0] w);
    logic [9:0] c;
    c = w[CODE_MSB:CODE_LSB];
    if (CODE_BITS == 8) begin
      c[1:0] = 2'h0;
    end
    return c;
  endfunction : codeField

  assign wrCode    = clockEnable && regWrite && regAddr == OFS_OUTPUT_CODE;
  assign wrCmd     = clockEnable && regWrite && regAddr == OFS_OPERATION;
  assign startHigh = wrCmd && regWdata[CMD_MSB:CMD_LSB] == CMD_MARGIN_HIGH;
  assign startLow  = wrCmd && regWdata[CMD_MSB:CMD_LSB] == CMD_MARGIN_LOW;

  // -----------------------------------------------------------------
  // write-only code registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      outputCode_r  <= CODE_RESET;
      upperMargin_r <= CODE_RESET;
      lowerMargin_r <= CODE_RESET;
    end else if (clockEnable && regWrite) begin
      case (regAddr)
        OFS_OUTPUT_CODE: outputCode_r  <= codeField(regWdata);
        OFS_UPPER_MARG:  upperMargin_r <= codeField(regWdata);
        OFS_LOWER_MARG:  lowerMargin_r <= codeField(regWdata);
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // operation command and power state
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      opCommand_r             <= CMD_RESET;
      outputPowerdownSelect_r <= PDN_HIGH_Z;
    end else if (wrCmd) begin
      opCommand_r <= regWdata[CMD_MSB:CMD_LSB];
      case (regWdata[CMD_MSB:CMD_LSB])
        CMD_TURN_OFF: outputPowerdownSelect_r <= powerdownMode;
        CMD_TURN_ON:  outputPowerdownSelect_r <= PDN_POWER_UP;
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // slew engine drives the active code
  // -----------------------------------------------------------------
  code_slewer u_slewer (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .jump        (wrCode),
    .jumpCode    (codeField(regWdata)),
    .slewStart   (startHigh || startLow),
    .slewTarget  (startHigh ? upperMargin_r : lowerMargin_r),
    .code_r      (slewCode),
    .slewing_r   (slewing)
  );
  always_ff @(posedge clock) begin
    if (reset) begin
      activeCode_r <= CODE_RESET;
    end else if (clockEnable) begin
      activeCode_r <= slewCode;
    end
  end

  // -----------------------------------------------------------------
  // margin trigger bits, cleared when the code arrives
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      marginHighBusy_r <= 1'b0;
      marginLowBusy_r  <= 1'b0;
    end else if (clockEnable) begin
      if (startHigh || startLow || wrCode) begin
        marginHighBusy_r <= startHigh;
        marginLowBusy_r  <= startLow;
      end else if (!slewing) begin
        marginHighBusy_r <= 1'b0;
        marginLowBusy_r  <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // communication fault flag: set wins over the write-one clear
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      commFaultFlag_r <= 1'b0;
    end else if (clockEnable) begin
      if (protocolError) begin
        commFaultFlag_r <= 1'b1;
      end else if (regWrite && regAddr == OFS_BUS_STATUS
                   && regWdata[FAULT_BIT]) begin
        commFaultFlag_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // read data; write-only registers read as zero
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      regRdata_r <= 16'h0000;
    end else if (clockEnable && regRead) begin
      regRdata_r <= 16'h0000;
      case (regAddr)
        OFS_OPERATION:  regRdata_r[CMD_MSB:CMD_LSB] <= opCommand_r;
        OFS_BUS_STATUS: regRdata_r[FAULT_BIT] <= commFaultFlag_r;
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // the output stage only copies the slewer while clock enable is high
  property p_codeWrite;
    @(posedge clock) disable iff (reset)
      wrCode ##1 clockEnable
      |=> activeCode_r == $past(codeField(regWdata), 2);
  endproperty
  a_codeWrite: assert property (p_codeWrite) else $error("code write lost");
  property p_faultSet;
    @(posedge clock) disable iff (reset)
      clockEnable && protocolError |=> commFaultFlag_r;
  endproperty
  a_faultSet: assert property (p_faultSet) else $error("fault not set");
  property p_faultClear;
    @(posedge clock) disable iff (reset)
      clockEnable && !protocolError && regWrite && regAddr == OFS_BUS_STATUS
      && regWdata[FAULT_BIT] |=> !commFaultFlag_r;
  endproperty
  a_faultClear: assert property (p_faultClear) else $error("no clear");
  property p_faultSticky;
    @(posedge clock) disable iff (reset)
      commFaultFlag_r && !(regWrite && regAddr == OFS_BUS_STATUS)
      |=> commFaultFlag_r;
  endproperty
  a_faultSticky: assert property (p_faultSticky) else $error("fault lost");
  property p_turnOn;
    @(posedge clock) disable iff (reset)
      wrCmd && regWdata[CMD_MSB:CMD_LSB] == CMD_TURN_ON
      |=> outputPowerdownSelect_r == PDN_POWER_UP;
  endproperty
  a_turnOn: assert property (p_turnOn) else $error("not powered up");
  property p_marginHighFlag;
    @(posedge clock) disable iff (reset)
      startHigh |=> marginHighBusy_r && !marginLowBusy_r;
  endproperty
  a_marginHighFlag: assert property (p_marginHighFlag) else $error("high");
  property p_marginLowFlag;
    @(posedge clock) disable iff (reset)
      startLow |=> marginLowBusy_r && !marginHighBusy_r;
  endproperty
  a_marginLowFlag: assert property (p_marginLowFlag) else $error("low");
  property p_selfClear;
    @(posedge clock) disable iff (reset)
      clockEnable && marginHighBusy_r && !slewing && !wrCmd && !wrCode
      |=> !marginHighBusy_r;
  endproperty
  a_selfClear: assert property (p_selfClear) else $error("no self clear");
  property p_readZero;
    @(posedge clock) disable iff (reset)
      clockEnable && regRead && regAddr == OFS_OUTPUT_CODE
      |=> regRdata_r == 16'h0000;
  endproperty
  a_readZero: assert property (p_readZero) else $error("wo read");
  property p_freeze;
    @(posedge clock) disable iff (reset)
      !clockEnable |=> $stable(activeCode_r) && $stable(commFaultFlag_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  c_margin: cover property (@(posedge clock) marginHighBusy_r ##1 !marginHighBusy_r);
  c_fault:  cover property (@(posedge clock) protocolError ##1 commFaultFlag_r);
  c_setWins: cover property (@(posedge clock) clockEnable && protocolError
    && regWrite && regAddr == OFS_BUS_STATUS && regWdata[FAULT_BIT]);
  c_off:    cover property (@(posedge clock) wrCmd && regWdata[15:8] == 8'h00);
endmodule : dac_code_margin_regs

/* File: dac_regs_pkg.sv */
/*
  Shared constants of the converter code and margin register bank:
  register offsets, field positions, reset values, operation commands,
  power-down selections and slew timing.
  Assumes a register access port driven by a bus front end in the same
  clock domain; nothing else is needed to compile it.
*/
package dac_regs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OPERATION   = 8'h01;
  localparam logic [7:0] OFS_OUTPUT_CODE = 8'h21;
  localparam logic [7:0] OFS_UPPER_MARG  = 8'h25;
  localparam logic [7:0] OFS_LOWER_MARG  = 8'h26;
  localparam logic [7:0] OFS_BUS_STATUS  = 8'h78;
  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int         CODE_MSB        = 11;
  localparam int         CODE_LSB        = 2;
  localparam int         CMD_MSB         = 15;
  localparam int         CMD_LSB         = 8;
  localparam int         FAULT_BIT       = 9;
  localparam logic [9:0] CODE_RESET      = 10'h000;
  localparam logic [7:0] CMD_RESET       = 8'h00;
  // ---------------------------------------------------------------
  // operation commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_TURN_OFF    = 8'h00;
  localparam logic [7:0] CMD_TURN_ON     = 8'h80;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'hA4;
  localparam logic [7:0] CMD_MARGIN_LOW  = 8'h94;
  // ---------------------------------------------------------------
  // power-down selection and slew timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PDN_POWER_UP    = 2'h0;
  localparam logic [1:0] PDN_HIGH_Z      = 2'h2;
  localparam int         CLOCK_HZ        = 20_000_000;
  localparam int         SLEW_STEP_NS    = 25_600;
  localparam int         SLEW_STEP_CYC   = SLEW_STEP_NS / (1_000_000_000 / CLOCK_HZ);
  localparam logic [9:0] SLEW_STEP_LSB   = 10'h001;
endpackage : dac_regs_pkg

/* File: host_model.sv */
/*
  Host model: issues register writes and reads on the bank's port.
  Assumes the testbench calls its tasks in the core clock domain.
*/
module host_model (
  input  wire logic        clock,
  output logic             regWrite,
  output logic             regRead,
  output logic      [7:0]  regAddr,
  output logic      [15:0] regWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 16'h0000;
  end
  // one-cycle strobe; data inverted on release so stale values show
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask : wr
  // read strobe; the answer is picked up by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
  endtask : rd
endmodule : host_model

/* File: testbench.sv */
/*
  Self-checking bench of the code and margin register bank.
  Assumes host_model and both code widths of the bank are compiled.
*/
module testbench;
  import dac_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        reset, clockEnable, protocolError, regWrite, regRead;
  logic        rdPend = 1'b0;
  logic        fault, hiBusy, loBusy;
  logic [1:0]  powerdownMode, pdnSel;
  logic [7:0]  regAddr;
  logic [9:0]  code, code8;
  logic [15:0] regWdata, regRdata, d;
  logic [15:0] expQ[$];
  int          num_errors = 0, compares = 0, seed = 35, i;

  always #25 clock = ~clock;

  host_model host (.clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata));
  dac_code_margin_regs #(.CODE_BITS(10)) DUT (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .protocolError(protocolError),
    .powerdownMode(powerdownMode), .regRdata_r(regRdata),
    .activeCode_r(code), .outputPowerdownSelect_r(pdnSel),
    .commFaultFlag_r(fault), .marginHighBusy_r(hiBusy),
    .marginLowBusy_r(loBusy));
  // eight-bit variant sees the same traffic; only its code is watched
  dac_code_margin_regs #(.CODE_BITS(8)) DUT8 (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .protocolError(protocolError),
    .powerdownMode(powerdownMode), .regRdata_r(), .activeCode_r(code8),
    .outputPowerdownSelect_r(), .commFaultFlag_r(), .marginHighBusy_r(),
    .marginLowBusy_r());

  // ------------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------------
  task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
    compares++;
    if (seen !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, seen);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task rdChk(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask : rdChk
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // read data is valid the cycle after the strobe is taken
  always @(posedge clock) begin
    if (rdPend && expQ.size() > 0)
      chk("read data", regRdata, expQ.pop_front());
    rdPend <= regRead & clockEnable;
  end
  // margin move: busy set, no jump, arrival, then busy self-clears
  task margin(input logic [7:0] cmd, input logic [9:0] tgt, input bit hi);
    host.wr(OFS_OPERATION, {cmd, 8'h00});
    tick(2);
    chk("margin busy", hi ? hiBusy : loBusy, 1);
    tick(8);
    chk("early arrival", code == tgt, 0);
    for (i = 0; i < 4000 && (hiBusy | loBusy) !== 1'b0; i++) tick(1);
    chk("margin code", code, tgt);
    chk("busy clear", {hiBusy, loBusy}, 0);
  endtask : margin

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    clockEnable = 1'b1;
    protocolError = 1'b0;
    powerdownMode = 2'h0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    tick(1);
    chk("reset code", code, 0);
    chk("reset power", pdnSel, PDN_HIGH_Z);
    chk("reset fault", fault, 0);
    rdChk(OFS_OPERATION, 16'h0000);
    rdChk(OFS_BUS_STATUS, 16'h0000);
    // random codes; ignored bits carry random junk as well
    for (int k = 0; k < 6; k++) begin
      d = 16'($random(seed));
      host.wr(OFS_OUTPUT_CODE, d);
      tick(2);
      chk("code", code, d[11:2]);
      chk("code8", code8, {d[11:4], 2'h0});
      rdChk(OFS_OUTPUT_CODE, 16'h0000);
    end
    rdChk(OFS_UPPER_MARG, 16'h0000);
    rdChk(OFS_LOWER_MARG, 16'h0000);
    rdChk(8'h55, 16'h0000);
    // turn off, turn on, then an inert command value
    powerdownMode <= 2'($random(seed));
    host.wr(OFS_OPERATION, {CMD_TURN_OFF, 8'hFF});
    tick(2);
    chk("off power", pdnSel, powerdownMode);
    rdChk(OFS_OPERATION, {CMD_TURN_OFF, 8'h00});
    host.wr(OFS_OPERATION, {CMD_TURN_ON, 8'h00});
    tick(2);
    chk("on power", pdnSel, PDN_POWER_UP);
    chk("on code", code, d[11:2]);
    rdChk(OFS_OPERATION, {CMD_TURN_ON, 8'h00});
    host.wr(OFS_OPERATION, 16'h3C00);
    rdChk(OFS_OPERATION, 16'h3C00);
    // small margins keep the slew short at the real step interval
    host.wr(OFS_OUTPUT_CODE, 16'h0008);
    host.wr(OFS_UPPER_MARG, 16'hF017);
    host.wr(OFS_LOWER_MARG, 16'h3006);
    host.wr(8'h55, 16'hFFFF);
    margin(CMD_MARGIN_HIGH, 10'h005, 1'b1);
    margin(CMD_MARGIN_LOW, 10'h001, 1'b0);
    // sticky fault: zero in bit 9 keeps it, one clears it
    @(posedge clock) protocolError <= 1'b1;
    @(posedge clock) protocolError <= 1'b0;
    tick(1);
    chk("fault set", fault, 1);
    rdChk(OFS_BUS_STATUS, 16'h0200);
    host.wr(OFS_BUS_STATUS, 16'hFDFF);
    tick(2);
    chk("fault kept", fault, 1);
    host.wr(OFS_BUS_STATUS, 16'h0200);
    tick(2);
    chk("fault clear", fault, 0);
    rdChk(OFS_BUS_STATUS, 16'h0000);
    // frozen clock enable: a code write and a fault pulse change nothing
    clockEnable <= 1'b0;
    host.wr(OFS_OUTPUT_CODE, 16'h0FFC);
    @(posedge clock) protocolError <= 1'b1;
    @(posedge clock) protocolError <= 1'b0;
    tick(2);
    chk("frozen code", code, 10'h001);
    chk("frozen fault", fault, 0);
    // fault and write-one clear in one cycle: the set wins
    clockEnable <= 1'b1;
    fork
      host.wr(OFS_BUS_STATUS, 16'h0200);
      @(posedge clock) protocolError <= 1'b1;
    join
    protocolError <= 1'b0;
    tick(2);
    chk("set wins", fault, 1);
    host.wr(OFS_BUS_STATUS, 16'h0200);
    tick(2);
    chk("fault clear again", fault, 0);
    tick(4);
    summarize();
  end
  // watchdog: whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    summarize();
  end
endmodule : testbench
